/* File: design/pic_pkg.sv */
// Shared constants, types and decode helpers of the interrupt controller
package pic_pkg;
    localparam int              NSLOT          = 24;
    localparam int              NCH            = 26;
    localparam int              NLVLREG        = 12;
    localparam int              NDMA           = 4;
    localparam int              NSTAT          = 5;
    localparam int              CH_NMI         = 0;
    localparam int              CH_WDT         = 1;
    localparam int              CH_SLOT0       = 2;
    localparam int              SLOT_EXT0      = 0;
    localparam int              SLOT_DMAEND0   = 20;
    localparam logic [NSLOT-1:0] SLOT_USED     = 24'hFFDFFF;
    localparam logic [7:0]      IDX_DMAV0      = 8'h80;
    localparam logic [7:0]      IDX_CLR        = 8'h88;
    localparam logic [7:0]      IDX_MODE       = 8'h8C;
    localparam logic [7:0]      IDX_STAT       = 8'hB0;
    localparam logic [7:0]      IDX_MASK       = 8'hB1;
    localparam logic [7:0]      LVL_IDX [NLVLREG] = '{8'h90, 8'h93, 8'h95, 8'h96, 8'h97, 8'h99,
                                                      8'h9B, 8'h9C, 8'h9D, 8'h9E, 8'hA0, 8'hA1};
    localparam int              MODE_EDGE_BIT  = 2;
    localparam int              MODE_LEVEL_BIT = 1;
    localparam int              MODE_NMI_BOTH  = 0;
    localparam int              STAT_NMI_BIT   = 4;
    localparam logic [2:0]      RST_MODE       = 3'h0;
    localparam logic [2:0]      RST_LEVEL      = 3'h0;
    localparam logic [5:0]      RST_DMAV       = 6'h00;
    localparam logic [NSTAT-1:0] RST_STAT      = 5'h00;
    localparam logic [2:0]      LVL_NMI        = 3'h7;
    localparam logic [2:0]      LVL_OFF        = 3'h0;
    // Vector numbering base is arbitrary; channel i uses base plus i
    localparam logic [5:0]      VEC_BASE       = 6'h08;
    localparam logic [1:0]      RESP_OKAY      = 2'h0;
    localparam logic [1:0]      RESP_SLVERR    = 2'h2;

    typedef logic [4:0] pic_chan_t;
    typedef logic [2:0] pic_level_t;

    function automatic logic pic_lvl_enabled(input pic_level_t code);
        return (code != 3'h0) && (code != 3'h7);
    endfunction : pic_lvl_enabled

    function automatic logic [5:0] pic_chan_vector(input int ch);
        return VEC_BASE + 6'(ch);
    endfunction : pic_chan_vector
endpackage : pic_pkg

/* File: design/pic_arb_if.sv */
// Carrier between the controller and its priority selector
`timescale 1ns/10ps
interface pic_arb_if;
    import pic_pkg::*;
    logic [NCH-1:0] pending;
    pic_level_t     level [NCH];
    logic           win_valid;
    pic_chan_t      win_idx;
    pic_level_t     win_level;
    modport ctrl (output pending, output level, input win_valid, input win_idx, input win_level);
    modport arb  (input pending, input level, output win_valid, output win_idx, output win_level);
endinterface : pic_arb_if

/* File: design/pic_arbiter.sv */
// Priority selector: highest level wins, lowest channel on a tie
`timescale 1ns/10ps
module pic_arbiter
    import pic_pkg::*;
(
    pic_arb_if.arb arb
);
    logic       best_v;
    pic_chan_t  best_i;
    pic_level_t best_l;

    always_comb begin
        best_v = 1'b0;
        best_i = '0;
        best_l = LVL_OFF;
        for (int i = 0; i < NCH; i++) begin
            // Strict compare keeps the lower vector on equal levels
            if (arb.pending[i] && (arb.level[i] > best_l)) begin
                best_v = 1'b1;
                best_i = 5'(i);
                best_l = arb.level[i];
            end
        end
    end

    assign arb.win_valid = best_v;
    assign arb.win_idx   = best_i;
    assign arb.win_level = best_l;
endmodule : pic_arbiter

/* File: design/pic_controller.sv */
// Prioritized interrupt controller with AXI4-Lite register slave
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/10ps
module pic_controller
    import pic_pkg::*;
(
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // AXI4-Lite slave
    input  wire logic [31:0]      s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [31:0]      s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    // Interrupt sources
    input  wire logic [NSLOT-1:0] periph_req,
    input  wire logic             ext0_pin,
    input  wire logic             nmi_n_pin,
    input  wire logic             wdt_req,
    // CPU side
    output logic                  cpu_irq_req,
    output logic [2:0]            cpu_irq_level,
    output logic [5:0]            cpu_irq_vector,
    input  wire logic             cpu_vector_ack,
    // DMA engine side
    output logic                  dma_req,
    output logic [1:0]            dma_chan,
    input  wire logic             dma_accept,
    input  wire logic [NDMA-1:0]  dma_burst_done,
    input  wire logic [NDMA-1:0]  dma_count_zero,
    // Summary interrupt
    output logic                  irq_out
);
    pic_arb_if arb_bus ();

    logic                  awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic                  aw_hold_reg, w_hold_reg;
    logic [1:0]            bresp_reg, rresp_reg;
    logic [31:0]           rdata_reg;
    logic [7:0]            widx_reg;
    logic [7:0]            wdata_reg;
    logic                  wlane_reg;
    logic                  wr_en;
    logic [2:0]            mode_reg;
    pic_level_t            lvl_reg [NSLOT];
    logic [5:0]            dmav_reg [NDMA];
    logic [NCH-1:0]        flag_reg;
    logic [NCH-1:0]        set_vec, clr_ack, clr_sw, clr_dma, clr_burst, clr_lvl, clr_all;
    logic [NSTAT-1:0]      status_reg, mask_reg;
    logic                  irq_req_reg, dma_req_reg, irq_out_reg;
    pic_level_t            irq_level_reg;
    logic [5:0]            irq_vector_reg;
    logic [1:0]            dma_chan_reg;
    pic_chan_t             pres_idx_reg;
    logic                  ext0_s1, ext0_s2, ext0_s3, nmi_s1, nmi_s2, nmi_s3;
    logic                  ext0_evt, nmi_evt;
    logic [2:0]            win_dma;
    logic                  ack_now, dacc_now;
    logic [31:0]           rd_data;
    logic                  rd_hit;

    pic_arbiter u_arb (
        .arb (arb_bus.arb)
    );

    // DMA vector lookup: hit flag and lowest matching channel number
    function automatic logic [2:0] dma_match(input logic [5:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int n = NDMA - 1; n >= 0; n--) begin
            if ((dmav_reg[n] != RST_DMAV) && (dmav_reg[n] == v)) begin
                r = {1'b1, 2'(n)};
            end
        end
        return r;
    endfunction : dma_match

    // ---------------- AXI4-Lite write path ----------------
    assign wr_en = aw_hold_reg && w_hold_reg && !bvalid_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
            aw_hold_reg <= 1'b0;
            w_hold_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
            widx_reg    <= 8'h00;
            wdata_reg   <= 8'h00;
            wlane_reg   <= 1'b0;
        end else begin
            if (s_axi_awvalid && awready_reg) begin
                widx_reg    <= s_axi_awaddr[9:2];
                aw_hold_reg <= 1'b1;
                awready_reg <= 1'b0;
            end
            if (s_axi_wvalid && wready_reg) begin
                wdata_reg  <= s_axi_wdata[7:0];
                wlane_reg  <= s_axi_wstrb[0];
                w_hold_reg <= 1'b1;
                wready_reg <= 1'b0;
            end
            if (wr_en) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= addr_known(widx_reg) ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_reg && s_axi_bready) begin
                bvalid_reg  <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg  <= 1'b1;
            end
        end
    end

    function automatic logic addr_known(input logic [7:0] idx);
        logic k;
        k = (idx == IDX_CLR) || (idx == IDX_MODE) || (idx == IDX_STAT) || (idx == IDX_MASK);
        for (int n = 0; n < NDMA; n++) begin
            k = k || (idx == IDX_DMAV0 + 8'(n));
        end
        for (int r = 0; r < NLVLREG; r++) begin
            k = k || (idx == LVL_IDX[r]);
        end
        return k;
    endfunction : addr_known

    // ---------------- AXI4-Lite read path ----------------
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit  = addr_known(s_axi_araddr[9:2]);
        for (int r = 0; r < NLVLREG; r++) begin
            if (s_axi_araddr[9:2] == LVL_IDX[r]) begin
                rd_data[7:0] = {flag_reg[CH_SLOT0 + 2*r + 1], lvl_reg[2*r + 1],
                                flag_reg[CH_SLOT0 + 2*r], lvl_reg[2*r]};
            end
        end
        for (int n = 0; n < NDMA; n++) begin
            if (s_axi_araddr[9:2] == IDX_DMAV0 + 8'(n)) begin
                rd_data[5:0] = dmav_reg[n];
            end
        end
        if (s_axi_araddr[9:2] == IDX_STAT) begin
            rd_data[NSTAT-1:0] = status_reg;
        end
        if (s_axi_araddr[9:2] == IDX_MASK) begin
            rd_data[NSTAT-1:0] = mask_reg;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= RESP_OKAY;
        end else if (s_axi_arvalid && arready_reg) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rdata_reg   <= rd_data;
            rresp_reg   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg  <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    // ---------------- Configuration registers ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg <= RST_MODE;
        end else if (wr_en && wlane_reg && (widx_reg == IDX_MODE)) begin
            mode_reg <= wdata_reg[2:0];
        end
    end

    always_ff @(posedge aclk) begin
        for (int r = 0; r < NLVLREG; r++) begin
            if (!aresetn) begin
                lvl_reg[2*r]     <= RST_LEVEL;
                lvl_reg[2*r + 1] <= RST_LEVEL;
            end else if (wr_en && wlane_reg && (widx_reg == LVL_IDX[r])) begin
                lvl_reg[2*r]     <= wdata_reg[2:0];
                lvl_reg[2*r + 1] <= SLOT_USED[2*r + 1] ? wdata_reg[6:4] : RST_LEVEL;
            end
        end
    end

    // Software write wins over the count-zero clear of the same cycle
    always_ff @(posedge aclk) begin
        for (int n = 0; n < NDMA; n++) begin
            if (!aresetn) begin
                dmav_reg[n] <= RST_DMAV;
            end else if (wr_en && wlane_reg && (widx_reg == IDX_DMAV0 + 8'(n))) begin
                dmav_reg[n] <= wdata_reg[5:0];
            end else if (dma_count_zero[n]) begin
                dmav_reg[n] <= RST_DMAV;
            end
        end
    end

    // ---------------- Pin synchronisers and detectors ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {ext0_s1, ext0_s2, ext0_s3} <= 3'h0;
            {nmi_s1, nmi_s2, nmi_s3}    <= 3'h7;
        end else begin
            {ext0_s1, ext0_s2, ext0_s3} <= {ext0_pin, ext0_s1, ext0_s2};
            {nmi_s1, nmi_s2, nmi_s3}    <= {nmi_n_pin, nmi_s1, nmi_s2};
        end
    end

    always_comb begin
        if (mode_reg[MODE_LEVEL_BIT]) begin
            ext0_evt = ext0_s2;
        end else if (mode_reg[MODE_EDGE_BIT]) begin
            ext0_evt = !ext0_s2 && ext0_s3;
        end else begin
            ext0_evt = ext0_s2 && !ext0_s3;
        end
        nmi_evt = (!nmi_s2 && nmi_s3) || (mode_reg[MODE_NMI_BOTH] && nmi_s2 && !nmi_s3);
    end

    // ---------------- Channel flags ----------------
    assign ack_now  = cpu_vector_ack && irq_req_reg;
    assign dacc_now = dma_accept && dma_req_reg;

    generate
        for (genvar c = 0; c < NCH; c++) begin : g_chan
            logic [NDMA-1:0] burst_hit;
            for (genvar n = 0; n < NDMA; n++) begin : g_burst
                assign burst_hit[n] = dma_burst_done[n] && (dmav_reg[n] != RST_DMAV)
                                      && (dmav_reg[n] == pic_chan_vector(c));
            end
            assign clr_ack[c]   = ack_now && (pres_idx_reg == 5'(c));
            assign clr_dma[c]   = dacc_now && (pres_idx_reg == 5'(c));
            assign clr_burst[c] = |burst_hit;
            assign clr_sw[c]    = wr_en && wlane_reg && (widx_reg == IDX_CLR)
                                  && (wdata_reg[5:0] == pic_chan_vector(c));
            if (c == CH_NMI) begin : g_nmi
                assign set_vec[c]       = nmi_evt;
                assign clr_lvl[c]       = 1'b0;
                assign arb_bus.level[c] = LVL_NMI;
            end else if (c == CH_WDT) begin : g_wdt
                assign set_vec[c]       = wdt_req;
                assign clr_lvl[c]       = 1'b0;
                assign arb_bus.level[c] = LVL_NMI;
            end else begin : g_mask
                localparam int S = c - CH_SLOT0;
                if (S == SLOT_EXT0) begin : g_ext
                    assign set_vec[c] = ext0_evt;
                    // Level mode drops the request once the pin falls
                    assign clr_lvl[c] = mode_reg[MODE_LEVEL_BIT] && !ext0_s2;
                end else if (S >= SLOT_DMAEND0) begin : g_tend
                    assign set_vec[c] = dma_count_zero[S - SLOT_DMAEND0];
                    assign clr_lvl[c] = 1'b0;
                end else begin : g_per
                    assign set_vec[c] = periph_req[S] && SLOT_USED[S];
                    assign clr_lvl[c] = 1'b0;
                end
                assign arb_bus.level[c] = (SLOT_USED[S] && pic_lvl_enabled(lvl_reg[S]))
                                          ? lvl_reg[S] : LVL_OFF;
            end
            assign arb_bus.pending[c] = flag_reg[c] && (arb_bus.level[c] != LVL_OFF);
        end
    endgenerate

    assign clr_all = clr_ack | clr_sw | clr_dma | clr_burst | clr_lvl;

    // A request arriving with its clear is kept
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_reg <= '0;
        end else begin
            flag_reg <= set_vec | (flag_reg & ~clr_all);
        end
    end

    // ---------------- Presentation to CPU and DMA ----------------
    assign win_dma = (arb_bus.win_idx >= 5'(CH_SLOT0)) ? dma_match(pic_chan_vector(arb_bus.win_idx))
                                                       : 3'h0;

    // Drop the request in the cycle it is consumed to avoid a double take
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_req_reg    <= 1'b0;
            dma_req_reg    <= 1'b0;
            irq_level_reg  <= LVL_OFF;
            irq_vector_reg <= 6'h00;
            dma_chan_reg   <= 2'h0;
            pres_idx_reg   <= '0;
        end else begin
            irq_req_reg    <= arb_bus.win_valid && !win_dma[2] && !ack_now && !dacc_now;
            dma_req_reg    <= arb_bus.win_valid && win_dma[2] && !ack_now && !dacc_now;
            irq_level_reg  <= arb_bus.win_level;
            irq_vector_reg <= pic_chan_vector(arb_bus.win_idx);
            dma_chan_reg   <= win_dma[1:0];
            pres_idx_reg   <= arb_bus.win_idx;
        end
    end

    // ---------------- Summary interrupt ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_reg  <= RST_STAT;
            mask_reg    <= RST_STAT;
            irq_out_reg <= 1'b0;
        end else begin
            if (wr_en && wlane_reg && (widx_reg == IDX_MASK)) begin
                mask_reg <= wdata_reg[NSTAT-1:0];
            end
            if (wr_en && wlane_reg && (widx_reg == IDX_STAT)) begin
                status_reg <= (status_reg & ~wdata_reg[NSTAT-1:0]) | {nmi_evt, dma_count_zero};
            end else begin
                status_reg <= status_reg | {nmi_evt, dma_count_zero};
            end
            irq_out_reg <= |(status_reg & mask_reg);
        end
    end

    assign s_axi_awready  = awready_reg;
    assign s_axi_wready   = wready_reg;
    assign s_axi_bvalid   = bvalid_reg;
    assign s_axi_bresp    = bresp_reg;
    assign s_axi_arready  = arready_reg;
    assign s_axi_rvalid   = rvalid_reg;
    assign s_axi_rdata    = rdata_reg;
    assign s_axi_rresp    = rresp_reg;
    assign cpu_irq_req    = irq_req_reg;
    assign cpu_irq_level  = irq_level_reg;
    assign cpu_irq_vector = irq_vector_reg;
    assign dma_req        = dma_req_reg;
    assign dma_chan       = dma_chan_reg;
    assign irq_out        = irq_out_reg;

    // ---------------- Checks ----------------
    flag_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> ((($past(flag_reg) & ~$past(clr_all)) | $past(set_vec)) == flag_reg))
        else $error("flag did not hold or catch");
    ack_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (|(clr_ack & ~set_vec)) |=> ((flag_reg & $past(clr_ack & ~set_vec)) == '0))
        else $error("vector fetch left flag set");
    sw_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (|(clr_sw & ~set_vec)) |=> ((flag_reg & $past(clr_sw & ~set_vec)) == '0))
        else $error("clear write left flag set");
    burst_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (|(clr_burst & ~set_vec)) |=> ((flag_reg & $past(clr_burst & ~set_vec)) == '0))
        else $error("burst end left flag set");
    mask_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (irq_req_reg && (pres_idx_reg >= 5'(CH_SLOT0)))
        |-> (irq_level_reg != LVL_OFF) && (irq_level_reg != LVL_NMI))
        else $error("disabled level presented");
    nmi_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (irq_req_reg && (pres_idx_reg < 5'(CH_SLOT0))) |-> (irq_level_reg == LVL_NMI))
        else $error("nonmaskable not at level 7");
    dma_split_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !(irq_req_reg && dma_req_reg))
        else $error("request on both paths");
    tend_stat_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (|dma_count_zero) |=> ((status_reg[NDMA-1:0] & $past(dma_count_zero))
                               == $past(dma_count_zero)))
        else $error("transfer end not recorded");
    read_lat_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && arready_reg) |=> rvalid_reg && !arready_reg)
        else $error("read answer late");
endmodule : pic_controller

/* File: bench/pic_cpu_model.sv */
// Behavioural CPU core and DMA engine facing the controller
`timescale 1ns/10ps
module pic_cpu_model
    import pic_pkg::*;
(
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Bench control
    input  wire logic       en,
    input  wire logic       ret,
    // Controller side
    input  wire logic       irq_req,
    input  wire logic [2:0] irq_level,
    input  wire logic       dma_req,
    output logic            ack,
    output logic            dma_accept
);
    logic [3:0] mask_reg;
    logic [3:0] saved_reg;
    logic       take;

    // Four bits so that level 7 plus one does not wrap to zero
    assign take = en && irq_req && !ack && ({1'b0, irq_level} > mask_reg);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ack        <= 1'b0;
            dma_accept <= 1'b0;
            mask_reg   <= 4'h0;
            saved_reg  <= 4'h0;
        end else begin
            ack        <= take;
            dma_accept <= en && dma_req && !dma_accept;
            if (take) begin
                saved_reg <= mask_reg;
                mask_reg  <= {1'b0, irq_level} + 4'h1;
            end else if (ret) begin
                mask_reg <= saved_reg;
            end
        end
    end
endmodule : pic_cpu_model

/* File: bench/test_prioritized_interrupt_controller.sv */
// Scenario bench for the interrupt controller
`timescale 1ns/10ps
module test_prioritized_interrupt_controller;
    import pic_pkg::*;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, wdt_req = 0, en = 0, ret = 0;
    logic ext0_pin = 0, nmi_n_pin = 1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic cpu_irq_req, cpu_vector_ack, dma_req, dma_accept, irq_out;
    logic [1:0] s_axi_bresp, s_axi_rresp, dma_chan;
    logic [2:0] cpu_irq_level;
    logic [5:0] cpu_irq_vector;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF, dma_count_zero = 4'h0, dma_burst_done = 4'h0;
    logic [NSLOT-1:0] periph_req = '0;
    int fails = 0, checks_done = 0;

    always #2 aclk = ~aclk;

    pic_controller DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .periph_req, .ext0_pin,
        .nmi_n_pin, .wdt_req, .cpu_irq_req, .cpu_irq_level, .cpu_irq_vector,
        .cpu_vector_ack, .dma_req, .dma_chan, .dma_accept, .dma_burst_done,
        .dma_count_zero, .irq_out);
    pic_cpu_model CPU (.aclk, .aresetn, .en, .ret, .irq_req(cpu_irq_req),
        .irq_level(cpu_irq_level), .dma_req, .ack(cpu_vector_ack), .dma_accept);

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    task automatic hang;
        fails++;
        wrap_up();
    endtask : hang

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] ix, input logic [7:0] v);
        int n;
        @(posedge aclk);
        s_axi_awaddr  <= {22'h0, ix, 2'h0};
        s_axi_wdata   <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        chk("bresp", 32'(RESP_OKAY), 32'(s_axi_bresp));
        if (n == 40) hang();
    endtask : wr

    task automatic rchk(input string nm, input logic [7:0] ix, input logic [31:0] e,
                        input logic [1:0] er = RESP_OKAY);
        int n;
        @(posedge aclk);
        s_axi_araddr  <= {22'h0, ix, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        chk(nm, e, s_axi_rdata);
        chk(nm, 32'(er), 32'(s_axi_rresp));
        s_axi_rready <= 1'b0;
        if (n == 40) hang();
    endtask : rchk

    task automatic pulse(input logic [NSLOT-1:0] p, input logic w, input logic [3:0] c);
        @(posedge aclk);
        periph_req     <= p;
        wdt_req        <= w;
        dma_count_zero <= c;
        @(posedge aclk);
        periph_req     <= '0;
        wdt_req        <= 1'b0;
        dma_count_zero <= 4'h0;
    endtask : pulse

    task automatic s_reset;
        rchk("level_rst", 8'h93, 32'h0);
        rchk("dmav_rst", 8'h80, 32'h0);
        rchk("unmapped", 8'h20, 32'h0, RESP_SLVERR);
    endtask : s_reset

    // Two equal levels at once, CPU masks the loser after the first accept
    task automatic s_prio;
        wr(8'h93, 8'h33);
        pulse(24'hC, 1'b0, 4'h0);
        tick(2);
        chk("req", 32'h1, 32'(cpu_irq_req));
        chk("vec_tie", 32'h0C, 32'(cpu_irq_vector));
        chk("lvl", 32'h3, 32'(cpu_irq_level));
        rchk("flags", 8'h93, 32'hBB);
        en <= 1'b1;
        tick(8);
        chk("vec_next", 32'h0D, 32'(cpu_irq_vector));
        rchk("after_ack", 8'h93, 32'hB3);
        wr(IDX_CLR, 8'h0D);
        rchk("after_clr", 8'h93, 32'h33);
        tick(2);
        chk("req_off", 32'h0, 32'(cpu_irq_req));
        en = 1'b0;
        ret = 1'b1;
        tick(1);
        ret = 1'b0;
    endtask : s_prio

    task automatic s_off;
        wr(8'h93, 8'h70);
        pulse(24'hC, 1'b0, 4'h0);
        tick(3);
        chk("req_dis", 32'h0, 32'(cpu_irq_req));
        rchk("flag_dis", 8'h93, 32'hF8);
        wr(IDX_CLR, 8'h0C);
        wr(IDX_CLR, 8'h0D);
    endtask : s_off

    task automatic s_wdt;
        pulse('0, 1'b1, 4'h0);
        tick(2);
        chk("wdt_lvl", 32'h7, 32'(cpu_irq_level));
        chk("wdt_vec", 32'h09, 32'(cpu_irq_vector));
        en = 1'b1;
        tick(4);
        chk("wdt_ack", 32'h0, 32'(cpu_irq_req));
        en = 1'b0;
    endtask : s_wdt

    task automatic s_dma;
        wr(8'h81, 8'h0C);
        wr(8'h93, 8'h01);
        pulse(24'h4, 1'b0, 4'h0);
        tick(2);
        chk("dma_req", 32'h1, 32'(dma_req));
        chk("dma_cpu", 32'h0, 32'(cpu_irq_req));
        chk("dma_chan", 32'h1, 32'(dma_chan));
        en = 1'b1;
        tick(4);
        en = 1'b0;
        rchk("dma_clr", 8'h93, 32'h01);
        pulse('0, 1'b0, 4'h2);
        rchk("dmav_zero", 8'h81, 32'h0);
        rchk("end_flag", 8'hA0, 32'h80);
        rchk("status", IDX_STAT, 32'h02);
        wr(IDX_MASK, 8'h02);
        tick(2);
        chk("irq_on", 32'h1, 32'(irq_out));
        wr(IDX_STAT, 8'h02);
        tick(2);
        chk("irq_clr", 32'h0, 32'(irq_out));
    endtask : s_dma

    task automatic s_pins;
        wr(8'h90, 8'h05);
        ext0_pin <= 1'b1;
        tick(6);
        chk("ext_vec", 32'h0A, 32'(cpu_irq_vector));
        wr(8'h82, 8'h0A);
        @(posedge aclk);
        dma_burst_done <= 4'h4;
        @(posedge aclk);
        dma_burst_done <= 4'h0;
        rchk("burst_clr", 8'h90, 32'h05);
        nmi_n_pin <= 1'b0;
        tick(6);
        chk("nmi_vec", 32'h08, 32'(cpu_irq_vector));
        wr(IDX_STAT, 8'h10);
        rchk("stat_w1c", IDX_STAT, 32'h0);
        wr(IDX_MODE, 8'h01);
        nmi_n_pin <= 1'b1;
        tick(6);
        rchk("nmi_both", IDX_STAT, 32'h10);
        wr(IDX_CLR, 8'h08);
    endtask : s_pins

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        s_reset();
        s_prio();
        s_off();
        s_wdt();
        s_dma();
        s_pins();
        wrap_up();
    end
endmodule : test_prioritized_interrupt_controller
